// [core/emfbo_top.v]
`timescale 1ns/1ps
`include "emfbo_consts.vh"
// ------------------------------------------------------------
// output and flag section of the microprogrammed emulator
// ------------------------------------------------------------
module emfbo_top (
    input  wire                        clock,
    input  wire                        nrst,
    input  wire [`EMFBO_UW_WIDTH-1:0]  next_microword,  // from microprogram memory
    input  wire [15:0]                 alu_result,      // slice y outputs
    input  wire                        zero_detect,     // wired zero detect
    input  wire                        top_result_bit,  // f3 of top slice
    input  wire                        top_carry,       // carry of top slice
    input  wire                        nib_carry,       // carry of lower nibble
    input  wire                        low_shift_out,   // shifted-out bit, low pair
    input  wire                        high_shift_out,  // shifted-out bit, high pair
    input  wire                        through_carry,   // rotate through carry select
    input  wire [7:0]                  data_in_latch,   // latched data bus input
    input  wire                        irq_request,     // pin
    input  wire                        ready,           // pin
    input  wire                        hold_request,    // pin
    output reg  [`EMFBO_UW_WIDTH-1:0]  microword,       // pipeline register
    output wire [8:0]                  slice_fn,
    output wire                        high_shift_in,
    output wire                        low_shift_in,
    output reg  [7:0]                  data_low_reg,
    output reg  [7:0]                  data_high_reg,
    output reg  [7:0]                  addr_low_reg,
    output reg  [7:0]                  addr_high_reg,
    output wire [15:0]                 addr_out,
    output wire                        addr_oe,
    output wire                        hold_granted,
    output reg  [7:0]                  data_out,
    output wire                        data_oe,
    output wire                        data_reg_load,
    output wire                        addr_reg_load,
    output wire                        irq_flag_load,
    output reg                         irq_enable_flag,
    output wire                        irq_accept,      // qualified interrupt
    output wire [4:0]                  flag_cond,       // aux, sign, parity, carry, zero
    output reg  [5:0]                  status_cond      // irq, ready, hold, f3, zero, carry
);
    // --------------------------------------------------------
    // internal signals
    // --------------------------------------------------------
    wire [2:0] pins_sync;      // irq, ready, hold after two stages
    wire       ready_sync;
    wire [1:0] dbus_sel;
    wire [1:0] load_sel;
    wire       any_ref;        // any reference bit active low
    wire       zero_flag;
    wire       parity_flag;
    wire       sign_flag;
    wire       aux_carry;
    wire       carry_bit;
    wire       new_parity;
    wire [7:0] flag_byte;

    // decodes shared by both select fields
    function sel_is;
        input [1:0] field;
        input [1:0] code;
        begin
            sel_is = (field == code);
        end
    endfunction

    // --------------------------------------------------------
    // microword pipeline
    // --------------------------------------------------------
    // loaded every cycle; reset value is all zero
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            microword <= {`EMFBO_UW_WIDTH{1'b0}};
        end else begin
            microword <= next_microword;
        end
    end

    assign slice_fn = microword[`EMFBO_FN_HI:`EMFBO_FN_LO];

    // --------------------------------------------------------
    // rotate shift-in: through carry or around
    // --------------------------------------------------------
    // carry update after rotate is left to the next microinstruction
    assign high_shift_in = through_carry ? carry_bit : high_shift_out;
    assign low_shift_in  = through_carry ? carry_bit : low_shift_out;

    // --------------------------------------------------------
    // pin synchroniser
    // --------------------------------------------------------
    emfbo_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({irq_request, ready, hold_request}),
        .dout  (pins_sync)
    );

    assign ready_sync = pins_sync[1];

    // --------------------------------------------------------
    // load decode
    // --------------------------------------------------------
    assign load_sel      = microword[`EMFBO_LOAD_HI:`EMFBO_LOAD_LO];
    assign any_ref       = ~&microword[`EMFBO_REF_HI:`EMFBO_REF_LO];
    assign data_reg_load = sel_is(load_sel, `EMFBO_SEL_ONE);
    // stall only matters on a reference; otherwise load goes ahead
    assign addr_reg_load = sel_is(load_sel, `EMFBO_SEL_TWO) &&
                           (ready_sync || !any_ref);
    assign irq_flag_load = sel_is(load_sel, `EMFBO_SEL_THREE);

    // --------------------------------------------------------
    // output registers
    // --------------------------------------------------------
    // low byte to low regs, high byte to high regs
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_low_reg  <= 8'h00;
            data_high_reg <= 8'h00;
            addr_low_reg  <= 8'h00;
            addr_high_reg <= 8'h00;
        end else begin
            if (data_reg_load) begin
                data_low_reg  <= alu_result[7:0];
                data_high_reg <= alu_result[15:8];
            end
            if (addr_reg_load) begin
                addr_low_reg  <= alu_result[7:0];
                addr_high_reg <= alu_result[15:8];
            end
        end
    end

    // --------------------------------------------------------
    // address bus enable and hold
    // --------------------------------------------------------
    assign addr_oe      = microword[`EMFBO_ADDR_EN];
    assign hold_granted = ~microword[`EMFBO_ADDR_EN];
    assign addr_out     = {addr_high_reg, addr_low_reg};

    // --------------------------------------------------------
    // interrupt enable flag
    // --------------------------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_enable_flag <= 1'b0;
        end else if (irq_flag_load) begin
            irq_enable_flag <= top_result_bit;
        end
    end

    // requests are ignored while the enable is clear
    assign irq_accept = pins_sync[2] & irq_enable_flag;

    // --------------------------------------------------------
    // flag store
    // --------------------------------------------------------
    assign new_parity = ~^alu_result[15:8];

    emfbo_flags u_flags (
        .clock        (clock),
        .nrst         (nrst),
        .src_fn       (microword[`EMFBO_SRC_HI:`EMFBO_SRC_LO]),
        .flag_hold    (microword[`EMFBO_FLAG_HOLD]),
        .carry_hold   (microword[`EMFBO_CARRY_HOLD]),
        .new_zero     (zero_detect),
        .new_parity   (new_parity),
        .new_sign     (alu_result[15]),
        .nib_carry    (nib_carry),
        .top_carry    (top_carry),
        .restore_data (data_in_latch),
        .zero_flag    (zero_flag),
        .parity_flag  (parity_flag),
        .sign_flag    (sign_flag),
        .aux_carry    (aux_carry),
        .carry_bit    (carry_bit)
    );

    // --------------------------------------------------------
    // data bus source
    // --------------------------------------------------------
    assign flag_byte = {sign_flag, zero_flag, 1'b0, aux_carry,
                        1'b0, parity_flag, 1'b1, carry_bit};
    assign dbus_sel  = microword[`EMFBO_DBUS_HI:`EMFBO_DBUS_LO];
    // code zero leaves the bus free for memory reads
    assign data_oe   = ~sel_is(dbus_sel, `EMFBO_SEL_NONE);

    // one source at most; mux keeps them exclusive
    always @* begin
        case (dbus_sel)
            `EMFBO_SEL_ONE:   data_out = data_low_reg;
            `EMFBO_SEL_TWO:   data_out = data_high_reg;
            `EMFBO_SEL_THREE: data_out = flag_byte;
            default:          data_out = 8'h00;
        endcase
    end

    // --------------------------------------------------------
    // condition inputs
    // --------------------------------------------------------
    assign flag_cond = {aux_carry, sign_flag, parity_flag,
                        carry_bit, zero_flag};

    // pins already doubly synced; micro-flags registered once
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_cond <= 6'h00;
        end else begin
            status_cond <= {pins_sync, top_result_bit, zero_detect, top_carry};
        end
    end
endmodule // emfbo_top

// [core/emfbo_consts.vh]
// Behaviour
// - slice function inputs from microword bits 0-8
// - low/high result bytes to data/address registers
// - parity flag is even parity of high byte
// - bit 27 enables address bus; hold floats it
// - bits 25/26 select one data bus source
// - bits 23/24 decode three register load enables
// - address load waits for ready on references
// - interrupt enable loaded from top result bit
// - interrupt recognised only while enable set
// - flags can be driven onto data bus
// - bit 20 holds zero/parity/sign/aux flags
// - zero flag from all slice zero detects
// - sign from top bit, aux from nibble carry
// - logic operations clear carry and aux carry
// - subtracts store inverted carry out
// - bit 21 holds the carry flag
// - nand code restores flags from data input register
// - stored flags feed condition multiplexers
// - requests and micro-flags registered each cycle
// - rotate through carry shifts carry flag in
// - 56-bit pipelined microword updated each cycle
// - right rotate shifts in own bit or carry
`ifndef EMFBO_CONSTS_VH
`define EMFBO_CONSTS_VH

// ------------------------------------------------------------
// microword field positions
// ------------------------------------------------------------
`define EMFBO_UW_WIDTH     56
`define EMFBO_FN_LO        0
`define EMFBO_FN_HI        8
`define EMFBO_SRC_LO       3
`define EMFBO_SRC_HI       5
`define EMFBO_SHIFT_DIR    7
`define EMFBO_FLAG_HOLD    20
`define EMFBO_CARRY_HOLD   21
`define EMFBO_LOAD_LO      23
`define EMFBO_LOAD_HI      24
`define EMFBO_DBUS_LO      25
`define EMFBO_DBUS_HI      26
`define EMFBO_ADDR_EN      27
`define EMFBO_REF_LO       28
`define EMFBO_REF_HI       31

// ------------------------------------------------------------
// function field codes
// ------------------------------------------------------------
`define EMFBO_OP_SUBR      3'h1
`define EMFBO_OP_SUBS      3'h2
`define EMFBO_OP_NAND      3'h5

// ------------------------------------------------------------
// select decodes (both two-bit fields)
// ------------------------------------------------------------
`define EMFBO_SEL_NONE     2'h0
`define EMFBO_SEL_ONE      2'h1
`define EMFBO_SEL_TWO      2'h2
`define EMFBO_SEL_THREE    2'h3

// ------------------------------------------------------------
// flag byte layout on the data bus and in restore data
// ------------------------------------------------------------
`define EMFBO_FB_CARRY     0
`define EMFBO_FB_ONE       1
`define EMFBO_FB_PARITY    2
`define EMFBO_FB_AUX       4
`define EMFBO_FB_ZERO      6
`define EMFBO_FB_SIGN      7

`endif

// [core/emfbo_sync.v]
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-stage synchroniser for a group of pin inputs
// ------------------------------------------------------------
module emfbo_sync #(
    parameter WIDTH = 3
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;   // first stage, read only by dout

    // first stage feeds second stage only
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // emfbo_sync

// [core/emfbo_flags.v]
`timescale 1ns/1ps
`include "emfbo_consts.vh"
// ------------------------------------------------------------
// condition flag store: update, hold and restore paths
// ------------------------------------------------------------
module emfbo_flags (
    input  wire       clock,
    input  wire       nrst,
    input  wire [2:0] src_fn,        // function bits 3..5
    input  wire       flag_hold,     // microword bit 20
    input  wire       carry_hold,    // microword bit 21
    input  wire       new_zero,
    input  wire       new_parity,
    input  wire       new_sign,
    input  wire       nib_carry,     // lower nibble carry of top byte
    input  wire       top_carry,     // top slice carry out
    input  wire [7:0] restore_data,  // latched data input register
    output reg        zero_flag,
    output reg        parity_flag,
    output reg        sign_flag,
    output reg        aux_carry,
    output reg        carry_bit
);
    wire logic_op;      // and/or/xor/nand group
    wire sub_op;        // the two subtracts
    wire restore_op;    // nand code reused for flag restore
    wire gen_aux;
    wire gen_carry;

    // codes 3..7 are logic operations
    assign logic_op   = (src_fn >= 3'h3);
    assign sub_op     = (src_fn == `EMFBO_OP_SUBR) ||
                        (src_fn == `EMFBO_OP_SUBS);
    assign restore_op = (src_fn == `EMFBO_OP_NAND);
    assign gen_aux    = nib_carry & ~logic_op;
    assign gen_carry  = logic_op ? 1'b0 :
                        (sub_op ? ~top_carry : top_carry);

    // restore beats hold beats fresh capture
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            zero_flag   <= 1'b0;
            parity_flag <= 1'b0;
            sign_flag   <= 1'b0;
            aux_carry   <= 1'b0;
            carry_bit   <= 1'b0;
        end else if (restore_op) begin
            zero_flag   <= restore_data[`EMFBO_FB_ZERO];
            parity_flag <= restore_data[`EMFBO_FB_PARITY];
            sign_flag   <= restore_data[`EMFBO_FB_SIGN];
            aux_carry   <= restore_data[`EMFBO_FB_AUX];
            carry_bit   <= restore_data[`EMFBO_FB_CARRY];
        end else begin
            if (!flag_hold) begin
                zero_flag   <= new_zero;
                parity_flag <= new_parity;
                sign_flag   <= new_sign;
                aux_carry   <= gen_aux;
            end
            if (!carry_hold) begin
                carry_bit <= gen_carry;
            end
        end
    end
endmodule // emfbo_flags

// [testbench/emfbo_top_asserts.sv]
`timescale 1ns/1ps
`include "emfbo_consts.vh"
// ------------------------------
// port checks, output and flags
// ------------------------------
module emfbo_checker (
    input wire logic [`EMFBO_UW_WIDTH-1:0] next_microword,
    input wire logic [`EMFBO_UW_WIDTH-1:0] microword,
    input wire logic                       clock,
    input wire logic                       nrst,
    input wire logic [8:0]                 slice_fn,
    input wire logic [15:0]                alu_result,
    input wire logic                       through_carry,
    input wire logic                       high_shift_out,
    input wire logic                       high_shift_in,
    input wire logic [7:0]                 data_low_reg,
    input wire logic [7:0]                 data_high_reg,
    input wire logic                       addr_oe,
    input wire logic                       hold_granted,
    input wire logic [7:0]                 data_out,
    input wire logic                       data_oe,
    input wire logic                       data_reg_load,
    input wire logic                       addr_reg_load,
    input wire logic                       irq_flag_load,
    input wire logic                       irq_enable_flag,
    input wire logic [4:0]                 flag_cond
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire [2:0] op = microword[5:3];   // function code
    wire [1:0] ds = microword[26:25]; // data bus source
    wire [1:0] ld = microword[24:23]; // load select
    // load cycle, then the capture edge
    sequence s_dload; data_reg_load ##1 1'b1; endsequence
    property p_fn; slice_fn == microword[8:0]; endproperty
    property p_bus; addr_oe == microword[27] && hold_granted == !microword[27]; endproperty
    property p_dsel; data_oe == (ds != 2'h0) && (ds != 2'h1 || data_out == data_low_reg)
        && (ds != 2'h2 || data_out == data_high_reg); endproperty
    property p_fbus; ds == 2'h3 |-> {data_out[7:6], data_out[4], data_out[2:0]} ==
        {flag_cond[3], flag_cond[0], flag_cond[4], flag_cond[2], 1'b1, flag_cond[1]}; endproperty
    property p_load; $onehot0({data_reg_load, addr_reg_load, irq_flag_load}) &&
        data_reg_load == (ld == 2'h1) && irq_flag_load == (ld == 2'h3)
        && (ld == 2'h2 || !addr_reg_load); endproperty
    property p_dload; s_dload |-> {data_high_reg, data_low_reg} == $past(alu_result); endproperty
    property p_pipe; 1'b1 |=> microword == $past(next_microword); endproperty
    property p_fhold; microword[20] && op != 3'h5 |=> $stable({flag_cond[4:2], flag_cond[0]});
    endproperty
    property p_chold; microword[21] && op != 3'h5 |=> $stable(flag_cond[1]); endproperty
    property p_logic; !microword[20] && !microword[21] && op >= 3'h3 && op != 3'h5
        |=> !flag_cond[1] && !flag_cond[4]; endproperty
    property p_par; !microword[20] && op != 3'h5 |=> flag_cond[2] == ~^$past(alu_result[15:8])
        && flag_cond[3] == $past(alu_result[15]); endproperty
    property p_shift; high_shift_in == (through_carry ? flag_cond[1] : high_shift_out); endproperty
    property p_irqen; irq_flag_load |=> irq_enable_flag == $past(alu_result[15]); endproperty
    a_fn: assert property (p_fn) else $error("slice function wrong");
    a_bus: assert property (p_bus) else $error("address enable wrong");
    a_dsel: assert property (p_dsel) else $error("data bus source wrong");
    a_fbus: assert property (p_fbus) else $error("flag byte wrong");
    a_load: assert property (p_load) else $error("load decode wrong");
    a_dload: assert property (p_dload) else $error("data regs wrong");
    a_pipe: assert property (p_pipe) else $error("pipeline wrong");
    a_fhold: assert property (p_fhold) else $error("flags not held");
    a_chold: assert property (p_chold) else $error("carry not held");
    a_logic: assert property (p_logic) else $error("logic op carry set");
    a_par: assert property (p_par) else $error("parity or sign wrong");
    a_shift: assert property (p_shift) else $error("shift input wrong");
    a_irqen: assert property (p_irqen) else $error("irq enable wrong");
endmodule // emfbo_checker
bind emfbo_top emfbo_checker emfbo_checker_inst (.next_microword(next_microword),
    .microword(microword), .clock(clock), .nrst(nrst), .slice_fn(slice_fn),
    .alu_result(alu_result), .through_carry(through_carry), .high_shift_out(high_shift_out),
    .high_shift_in(high_shift_in), .data_low_reg(data_low_reg), .data_high_reg(data_high_reg),
    .addr_oe(addr_oe), .hold_granted(hold_granted), .data_out(data_out), .data_oe(data_oe),
    .data_reg_load(data_reg_load), .addr_reg_load(addr_reg_load),
    .irq_flag_load(irq_flag_load), .irq_enable_flag(irq_enable_flag), .flag_cond(flag_cond));

// [testbench/emfbo_mem_model.sv]
`timescale 1ns/1ps
// ------------------------------
// system memory on the buses
// ------------------------------
module emfbo_mem_model (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [15:0] addr,     // address bus
    input  wire logic        addr_en,  // address bus driven
    input  wire logic [7:0]  wdata,    // data bus from device
    input  wire logic        wdata_en, // device drives data bus
    input  wire logic [3:0]  ref_n,    // references, active low
    input  wire logic        stall,    // answer slowly while high
    output wire logic        ready,
    output logic      [7:0]  rd_latch  // data input latch
);
    logic [7:0] mem [0:255]; // small window, tests stay low
    assign ready = !stall;
    // writes only on a finished reference with both buses driven
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_latch <= 8'h00;
        end else begin
            if (addr_en && wdata_en && ref_n != 4'hf && ready) begin
                mem[addr[7:0]] <= wdata;
            end
            // floating bus gives a changing pattern, not the last value
            if (addr_en && !wdata_en) rd_latch <= mem[addr[7:0]];
            else rd_latch <= ~rd_latch;
        end
    end
    initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
endmodule // emfbo_mem_model

// [testbench/tb_emulator_flag_and_bus_output.sv]
`timescale 1ns/1ps
`include "emfbo_consts.vh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb_emulator_flag_and_bus_output;
    localparam logic [55:0] IDLE = 56'h000000f8300000; // holds set, no load, no reference
    logic        clock, nrst, zero_detect, top_carry, nib_carry, lso, hso, through_carry;
    logic        irq_request, hold_request, stall, ready, high_shift_in, low_shift_in;
    logic        addr_oe, hold_granted, data_oe, data_reg_load, addr_reg_load, irq_flag_load;
    logic        irq_enable_flag, irq_accept;
    logic [55:0] next_microword, microword;
    logic [15:0] alu_result, addr_out;
    logic [8:0]  slice_fn;
    logic [7:0]  dil, data_low_reg, data_high_reg, addr_low_reg, addr_high_reg, data_out;
    logic [4:0]  flag_cond;
    logic [5:0]  status_cond;
    logic [3:0]  i;
    integer      n_mismatch, n_compared;
    emfbo_top emfbo_top_inst (.clock(clock), .nrst(nrst), .next_microword(next_microword),
        .alu_result(alu_result), .zero_detect(zero_detect), .top_result_bit(alu_result[15]),
        .top_carry(top_carry), .nib_carry(nib_carry), .low_shift_out(lso),
        .high_shift_out(hso), .through_carry(through_carry), .data_in_latch(dil),
        .irq_request(irq_request), .ready(ready), .hold_request(hold_request),
        .microword(microword), .slice_fn(slice_fn), .high_shift_in(high_shift_in),
        .low_shift_in(low_shift_in), .data_low_reg(data_low_reg), .data_high_reg(data_high_reg),
        .addr_low_reg(addr_low_reg), .addr_high_reg(addr_high_reg), .addr_out(addr_out),
        .addr_oe(addr_oe), .hold_granted(hold_granted), .data_out(data_out), .data_oe(data_oe),
        .data_reg_load(data_reg_load), .addr_reg_load(addr_reg_load),
        .irq_flag_load(irq_flag_load), .irq_enable_flag(irq_enable_flag),
        .irq_accept(irq_accept), .flag_cond(flag_cond), .status_cond(status_cond));
    emfbo_mem_model emfbo_mem_model_inst (.clock(clock), .nrst(nrst), .addr(addr_out),
        .addr_en(addr_oe), .wdata(data_out), .wdata_en(data_oe), .ref_n(microword[31:28]),
        .stall(stall), .ready(ready), .rd_latch(dil));
    // build a microword from its control fields
    function automatic [55:0] uw(input [2:0] op, input [1:0] hold, ld, ds, input ae,
                                 input [3:0] rf);
        uw = IDLE;
        uw[5:3] = op;
        uw[21:20] = hold;
        uw[24:23] = ld;
        uw[26:25] = ds;
        uw[27] = ae;
        uw[31:28] = rf;
    endfunction
    // expected {aux, sign, parity, carry, zero} for a normal update
    function automatic [4:0] fexp(input [2:0] op, input [15:0] r, input zd, tc, nc);
        logic lg;
        lg = op >= 3'h3;
        fexp = {nc & !lg, r[15], ~^r[15:8], lg ? 1'b0 : ((op == 3'h1 || op == 3'h2) ^ tc), zd};
    endfunction
    // word in, then datapath levels during its cycle
    task automatic step(input [55:0] mw, input [15:0] res, input zd, tc, nc);
        @(posedge clock) #1 next_microword = mw;
        @(posedge clock) #1 next_microword = IDLE;
        alu_result = res;
        zero_detect = zd;
        top_carry = tc;
        nib_carry = nc;
    endtask
    task automatic settle; @(posedge clock) #1; endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    // watchdog at 1000 cycles: tests need well under that
    initial begin
        #100000 n_mismatch++;
        end_sim;
    end
    initial begin
        {nrst, zero_detect, top_carry, nib_carry, lso, hso, through_carry} = 7'h00;
        {irq_request, hold_request, stall, n_mismatch, n_compared} = '0;
        next_microword = '0;
        alu_result = '0;
        repeat (2) @(posedge clock);
        `CHK("reset", {addr_oe, hold_granted, data_oe, flag_cond}, 8'h40)
        #1 nrst = 1;
        step(uw(3'h0, 2'h3, 2'h1, 2'h0, 1, 4'hf), 16'ha55a, 0, 0, 0);
        step(uw(3'h0, 2'h3, 2'h0, 2'h1, 1, 4'hf), 16'h0000, 0, 0, 0);
        `CHK("dbus low", {data_oe, data_out}, 9'h15a)
        step(uw(3'h0, 2'h3, 2'h0, 2'h2, 1, 4'hf), 16'h0000, 0, 0, 0);
        `CHK("dbus high", {data_oe, data_out}, 9'h1a5)
        settle;
        `CHK("dbus free", data_oe, 1'b0)
        $display("test data path done");
        step(uw(3'h0, 2'h3, 2'h2, 2'h0, 1, 4'he), 16'h1234, 0, 0, 0);
        settle;
        `CHK("addr", {addr_oe, addr_out, addr_high_reg, addr_low_reg}, 33'h1_1234_1234)
        stall = 1;
        repeat (4) settle;
        step(uw(3'h0, 2'h3, 2'h2, 2'h0, 1, 4'he), 16'h9999, 0, 0, 0);
        settle;
        `CHK("addr blocked", addr_out, 16'h1234)
        step(uw(3'h0, 2'h3, 2'h2, 2'h0, 1, 4'hf), 16'h7777, 0, 0, 0);
        settle;
        `CHK("addr no ref", addr_out, 16'h7777)
        stall = 0;
        repeat (4) settle;
        step(uw(3'h0, 2'h3, 2'h2, 2'h0, 1, 4'he), 16'h0010, 0, 0, 0);
        settle;
        `CHK("addr ready", addr_out, 16'h0010)
        step(uw(3'h0, 2'h3, 2'h0, 2'h0, 0, 4'hf), 16'h0000, 0, 0, 0);
        `CHK("hold float", {addr_oe, hold_granted}, 2'b01)
        $display("test address done");
        for (i = 0; i < 8; i++) if (i != 5) begin
            step(uw(i[2:0], 2'h0, 2'h0, 2'h0, 1, 4'hf), {i[2:0], i[0], 12'h93c}, i[1], i[0], 1);
            settle;
            `CHK("flags", flag_cond, fexp(i[2:0], {i[2:0], i[0], 12'h93c}, i[1], i[0], 1))
        end
        step(uw(3'h0, 2'h0, 2'h0, 2'h0, 1, 4'hf), 16'h8100, 1, 1, 1);
        step(uw(3'h0, 2'h1, 2'h0, 2'h0, 1, 4'hf), 16'h0000, 0, 0, 0);
        settle;
        `CHK("flag hold", flag_cond, 5'h1d)
        step(uw(3'h0, 2'h2, 2'h0, 2'h0, 1, 4'hf), 16'h0000, 0, 1, 0);
        settle;
        `CHK("carry hold", flag_cond, 5'h04)
        step(uw(3'h0, 2'h3, 2'h0, 2'h3, 1, 4'hd), 16'h0000, 0, 0, 0);
        `CHK("flag byte", {data_out[7:6], data_out[4], data_out[2:0]}, 6'h06)
        step(uw(3'h0, 2'h0, 2'h0, 2'h0, 1, 4'hf), 16'h8100, 1, 1, 1);
        settle;
        through_carry = 1;
        #1 `CHK("rotate thru", {high_shift_in, low_shift_in}, 2'b11)
        settle;
        {through_carry, hso, lso} = 3'b001;
        #1 `CHK("rotate around", {high_shift_in, low_shift_in}, 2'b01)
        step(uw(3'h5, 2'h3, 2'h0, 2'h0, 1, 4'he), 16'h8100, 1, 1, 1);
        settle;
        `CHK("restore", flag_cond, 5'h04)
        $display("test flags done");
        {irq_request, hold_request} = 2'b11;
        step(uw(3'h0, 2'h3, 2'h3, 2'h0, 1, 4'hf), 16'h8000, 0, 0, 0);
        repeat (4) settle;
        `CHK("irq on", {irq_enable_flag, irq_accept, status_cond}, 8'hfc)
        step(uw(3'h0, 2'h3, 2'h3, 2'h0, 1, 4'hf), 16'h0000, 0, 0, 0);
        settle;
        `CHK("irq off", {irq_enable_flag, irq_accept}, 2'b00)
        $display("test interrupt enable done");
        end_sim;
    end
endmodule // tb_emulator_flag_and_bus_output
